// File: hdl/cer_top.sv
// Configurable embedded RAM: APB configuration, shape checks and user ports
// Function
// - Same-address writes both ports make word unknown
// - Falling-edge style captures rising, commits falling
// - Write data and address registered on rising edge
// - Port shape is depth times data width
// - Mid block widest shapes limited to three modes
// - Oversize requests cascade more same-type blocks; here the block count is reported for mid blocks only
// - Dedicated blocks keep exact non-power-of-two depth
// - Logic cells decode every address-width location
// - Mixed widths only dual-port, never logic cells; here true dual-port RAM and dual-port ROM only, not simple dual-port
// - Mixed widths need two words per port
// - Max block depth reshapes block wider word
// - Max block depth power of two, ranged
// - Clock modes restricted by memory mode
// - No asynchronous clocking except unregistered small-block read
// - Single clock drives all registered ports
// - Read/write clocks split read and write registers; here read and write registers all run on clk
// - Input clock inputs, output clock output data; here inputs and output data both run on clk
// - Small block reads continuously after write
// - Independent mode clocks each port's registers; here both ports' registers run on clk
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
module cer_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // User port A
   input  wire logic                        aWrEn,
   input  wire logic [cer_pkg::ADDR_W-1:0]  aAddr,
   input  wire logic [cer_pkg::DATA_W-1:0]  aWrData,
   output logic      [cer_pkg::DATA_W-1:0]  aRdData,
   output logic                             aRdUnknown,
   // User port B
   input  wire logic                        bWrEn,
   input  wire logic [cer_pkg::ADDR_W-1:0]  bAddr,
   input  wire logic [cer_pkg::DATA_W-1:0]  bWrData,
   output logic      [cer_pkg::DATA_W-1:0]  bRdData,
   output logic                             bRdUnknown,
   // Status
   output logic                             cfgOk,
   output logic                             wrContention
);
   logic        rstMeta_reg;
   logic        rstSync_reg;
   logic [10:0] ctrl_reg;
   logic [27:0] geom_reg;
   logic [17:0] maxDep_reg;
   logic [15:0] contend_reg;
   logic [15:0] contend_next;
   logic        weA_reg;
   logic        weB_reg;
   logic [7:0]  waA_reg;
   logic [7:0]  waB_reg;
   logic [17:0] wdA_reg;
   logic [17:0] wdB_reg;
   logic [31:0] rdMux;
   wire         rstSyncN = rstSync_reg;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   // Configuration fields
   wire [2:0]  memMode = ctrl_reg[cer_pkg::CTRL_MODE_LSB +: 3];
   wire [2:0]  clkMode = ctrl_reg[cer_pkg::CTRL_CLK_LSB +: 3];
   wire [1:0]  blkType = ctrl_reg[cer_pkg::CTRL_BLK_LSB +: 2];
   wire        emuStyle = ctrl_reg[cer_pkg::CTRL_EMU_BIT];
   wire        unregRd = ctrl_reg[cer_pkg::CTRL_UNREG_BIT];
   wire        enable = ctrl_reg[cer_pkg::CTRL_EN_BIT];
   wire [15:0] depthCfg = geom_reg[15:0];
   wire [5:0]  widthA = geom_reg[cer_pkg::GEOM_WA_LSB +: 6];
   wire [5:0]  widthB = geom_reg[cer_pkg::GEOM_WB_LSB +: 6];

   wire blkMid   = blkType == cer_pkg::BLK_MID;
   wire blkSmall = blkType == cer_pkg::BLK_SMALL;
   wire blkLarge = blkType == cer_pkg::BLK_LARGE;
   wire blkLogic = blkType == cer_pkg::BLK_LOGIC;
   wire isRom    = memMode == cer_pkg::MODE_SP_ROM || memMode == cer_pkg::MODE_DP_ROM;
   wire isDual   = memMode == cer_pkg::MODE_TDP_RAM || memMode == cer_pkg::MODE_DP_ROM;
   wire isSplit  = memMode == cer_pkg::MODE_SDP_RAM || memMode == cer_pkg::MODE_TRI_RAM;
   wire mixed    = widthA != widthB;
   wire [5:0] wideW   = (widthA > widthB) ? widthA : widthB;
   wire [5:0] narrowW = (widthA > widthB) ? widthB : widthA;

   // Shape checks; each bit refuses the configuration
   wire wideOk = memMode == cer_pkg::MODE_SP_RAM || memMode == cer_pkg::MODE_SDP_RAM
                 || memMode == cer_pkg::MODE_SP_ROM;
   wire errShape = blkMid && maxDep_reg == cer_pkg::MID_WIDE_DEP && !wideOk;
   wire errMixed = mixed && (!isDual || blkLogic);
   wire [21:0] narrowBits = depthCfg * narrowW;
   wire [21:0] minBits = 22'(wideW) * 22'(cer_pkg::MIN_MIXED_WORDS);
   wire errWords = mixed && narrowBits < minBits;
   wire maxDepPow2 = (maxDep_reg & (maxDep_reg - 18'h00001)) == 18'h00000;
   wire maxDepInRange =
        (blkMid && maxDep_reg >= cer_pkg::MID_MIN_DEP && maxDep_reg <= cer_pkg::MID_DEF_DEP)
     || (blkSmall && maxDep_reg >= cer_pkg::SMALL_MIN_DEP
                  && maxDep_reg <= cer_pkg::SMALL_MAX_DEP)
     || (blkLarge && maxDep_reg >= cer_pkg::LARGE_MIN_DEP
                  && maxDep_reg <= cer_pkg::LARGE_MAX_DEP);
   wire errMaxDep = maxDep_reg != 18'h00000 && (!maxDepPow2 || !maxDepInRange);
   wire clkOkRdwr = clkMode == cer_pkg::CLK_RDWR && isSplit;
   wire clkOkIndep = clkMode == cer_pkg::CLK_INDEP && isDual;
   wire clkOkAsync = clkMode == cer_pkg::CLK_ASYNC && blkSmall
                     && memMode == cer_pkg::MODE_SDP_RAM && unregRd;
   wire errClock = !(clkMode == cer_pkg::CLK_SINGLE || clkMode == cer_pkg::CLK_INOUT
                     || clkOkRdwr || clkOkIndep || clkOkAsync);

   // Real addressable depth
   function automatic logic [16:0] pow2Ceil(input logic [15:0] d);
      logic [16:0] p;
      p = 17'h00001;
      for (int i = 0; i < 16; i++) begin
         if (p < {1'b0, d})
            p = {p[15:0], 1'b0};
      end
      return p;
   endfunction
   wire [16:0] effDepth = (blkLogic && !emuStyle) ? pow2Ceil(depthCfg)
                                                  : {1'b0, depthCfg};
   wire errCap = effDepth > cer_pkg::ARRAY_DEP_V || wideW > cer_pkg::DATA_W_V
                 || depthCfg == 16'h0000;
   wire [5:0] cfgErr = {errCap, errClock, errMaxDep, errWords, errMixed, errShape};
   wire cfgGood = enable && cfgErr == 6'h00;

   // Blocks a mid-block build needs: slice word width, then cascade
   wire [17:0] sliceDep = (maxDep_reg == 18'h00000) ? cer_pkg::MID_DEF_DEP : maxDep_reg;
   wire [17:0] sliceW = (sliceDep == 18'h00000) ? 18'h00001
                                                : cer_pkg::MID_BITS / sliceDep;
   wire [17:0] blkAcross = (18'(wideW) + sliceW - 18'h00001) / sliceW;
   wire [17:0] blkDown = (18'(depthCfg) + sliceDep - 18'h00001) / sliceDep;
   wire [35:0] blkProd = blkAcross * blkDown;
   wire [15:0] blocksUsed = (blkMid && !errMaxDep) ? blkProd[15:0] : 16'h0000;

   // User port legality
   wire aAddrOk = {9'h000, aAddr} < effDepth;
   wire bAddrOk = {9'h000, bAddr} < effDepth;
   wire aWrOk = cfgGood && !isRom && aWrEn && aAddrOk;
   wire bWrOk = cfgGood && memMode == cer_pkg::MODE_TDP_RAM && bWrEn && bAddrOk;
   wire aRdOk = cfgGood && aAddrOk;
   wire bRdOk = cfgGood && bAddrOk && memMode != cer_pkg::MODE_SP_RAM
                && memMode != cer_pkg::MODE_SP_ROM;
   wire hitClash = weA_reg && weB_reg && waA_reg == waB_reg;

   // All port registers share clk, whatever clock mode is recorded
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         weA_reg <= 1'b0;
         weB_reg <= 1'b0;
         waA_reg <= 8'h00;
         waB_reg <= 8'h00;
         wdA_reg <= 18'h00000;
         wdB_reg <= 18'h00000;
      end else begin
         weA_reg <= aWrOk;
         weB_reg <= bWrOk;
         waA_reg <= aAddr;
         waB_reg <= bAddr;
         wdA_reg <= aWrData;
         wdB_reg <= bWrData;
      end
   end

   cer_mem uMem (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .weA      (weA_reg),
      .waA      (waA_reg),
      .wdA      (wdA_reg),
      .weB      (weB_reg),
      .waB      (waB_reg),
      .wdB      (wdB_reg),
      .reA      (aRdOk),
      .raA      (aAddr),
      .reB      (bRdOk),
      .raB      (bAddr),
      .rdA      (aRdData),
      .unkA     (aRdUnknown),
      .rdB      (bRdData),
      .unkB     (bRdUnknown)
   );

   // APB decode: one wait state, then pready
   wire apbAccess = psel && penable && !pready;
   wire apbDone = psel && penable && pready;
   wire wrDone = apbDone && pwrite;
   wire hitCtrl = paddr == cer_pkg::OFF_CTRL;
   wire hitGeom = paddr == cer_pkg::OFF_GEOM;
   wire hitMaxDep = paddr == cer_pkg::OFF_MAXDEP;
   wire hitStatus = paddr == cer_pkg::OFF_STATUS;
   wire hitContend = paddr == cer_pkg::OFF_CONTEND;
   wire hitEffDep = paddr == cer_pkg::OFF_EFFDEP;
   wire mapped = hitCtrl || hitGeom || hitMaxDep || hitStatus || hitContend || hitEffDep;
   wire [31:0] statusWord = {blocksUsed, 7'h00, cfgGood, 2'h0, cfgErr};

   always_comb begin
      rdMux = 32'h00000000;
      if (hitCtrl)
         rdMux = {21'h000000, ctrl_reg};
      else if (hitGeom)
         rdMux = {4'h0, geom_reg};
      else if (hitMaxDep)
         rdMux = {14'h0000, maxDep_reg};
      else if (hitStatus)
         rdMux = statusWord;
      else if (hitContend)
         rdMux = {16'h0000, contend_reg};
      else if (hitEffDep)
         rdMux = {15'h0000, effDepth};
   end

   // Contention counter: a new hit with a software clear restarts the count at one
   always_comb begin
      contend_next = contend_reg;
      if (hitClash)
         contend_next = (wrDone && hitContend) ? 16'h0001 : contend_reg + 16'h0001;
      else if (wrDone && hitContend)
         contend_next = 16'h0000;
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= apbAccess;
         pslverr <= apbAccess && !mapped;
         prdata  <= (apbAccess && !pwrite) ? rdMux : 32'h00000000;
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ctrl_reg   <= cer_pkg::CTRL_RST;
         geom_reg   <= cer_pkg::GEOM_RST;
         maxDep_reg <= cer_pkg::MAXDEP_RST;
      end else if (wrDone) begin
         if (hitCtrl)
            ctrl_reg <= pwdata[10:0];
         if (hitGeom)
            geom_reg <= pwdata[27:0];
         if (hitMaxDep)
            maxDep_reg <= pwdata[17:0];
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         contend_reg  <= 16'h0000;
         wrContention <= 1'b0;
         cfgOk        <= 1'b0;
      end else begin
         contend_reg  <= contend_next;
         wrContention <= hitClash;
         cfgOk        <= cfgGood;
      end
   end

   // Checks
   chk_clash_flag: assert property (@(posedge clk) disable iff (!rstSyncN)
      weA_reg && weB_reg && waA_reg == waB_reg |=> wrContention)
      else $error("contention not flagged");
   chk_capture_addr: assert property (@(posedge clk) disable iff (!rstSyncN)
      aWrOk |=> weA_reg && waA_reg == $past(aAddr) && wdA_reg == $past(aWrData))
      else $error("write not captured on rising edge");
   chk_wide_shape: assert property (@(posedge clk) disable iff (!rstSyncN)
      blkMid && maxDep_reg == 18'h00100 && memMode == cer_pkg::MODE_TDP_RAM |=> !cfgOk)
      else $error("wide shape accepted in true dual-port");
   chk_mixed_logic: assert property (@(posedge clk) disable iff (!rstSyncN)
      widthA != widthB && blkLogic |=> !cfgOk)
      else $error("mixed width accepted in logic cells");
   chk_one_word: assert property (@(posedge clk) disable iff (!rstSyncN)
      mixed && narrowBits < 22'(wideW) * 22'h2 |=> !cfgOk)
      else $error("one-word mixed port accepted");
   chk_logic_depth: assert property (@(posedge clk) disable iff (!rstSyncN)
      blkLogic && !emuStyle && depthCfg == 16'h0003 |-> effDepth == 17'h00004)
      else $error("logic cell depth not rounded to power of two");
   chk_block_depth: assert property (@(posedge clk) disable iff (!rstSyncN)
      !blkLogic |-> effDepth == {1'b0, depthCfg})
      else $error("block depth altered");
   chk_async_clock: assert property (@(posedge clk) disable iff (!rstSyncN)
      clkMode == cer_pkg::CLK_ASYNC && !blkSmall |=> !cfgOk)
      else $error("asynchronous clocking accepted");
   chk_rdwr_clock: assert property (@(posedge clk) disable iff (!rstSyncN)
      clkMode == cer_pkg::CLK_RDWR && memMode == cer_pkg::MODE_TDP_RAM |=> !cfgOk)
      else $error("read/write clocking accepted in true dual-port");
   chk_apb_answer: assert property (@(posedge clk) disable iff (!rstSyncN)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("APB answer timing wrong");
endmodule

// File: hdl/cer_pkg.sv
// Shared constants for the configurable embedded RAM block
package cer_pkg;
   // Physical array
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 18;
   localparam int unsigned ARRAY_DEP = 256;
   localparam logic [16:0] ARRAY_DEP_V = 17'h00100;
   localparam logic [5:0]  DATA_W_V    = 6'h12;

   // APB map, byte addresses
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_GEOM     = 8'h04;
   localparam logic [7:0] OFF_MAXDEP   = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0c;
   localparam logic [7:0] OFF_CONTEND  = 8'h10;
   localparam logic [7:0] OFF_EFFDEP   = 8'h14;

   // Reset values
   localparam logic [10:0] CTRL_RST   = 11'h000;
   localparam logic [27:0] GEOM_RST   = 28'h4920100;
   localparam logic [17:0] MAXDEP_RST = 18'h00000;

   // Control, shape and status fields
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_CLK_LSB  = 3;
   localparam int unsigned CTRL_BLK_LSB  = 6;
   localparam int unsigned CTRL_EMU_BIT  = 8;
   localparam int unsigned CTRL_UNREG_BIT = 9;
   localparam int unsigned CTRL_EN_BIT   = 10;
   localparam int unsigned GEOM_WA_LSB   = 16;
   localparam int unsigned GEOM_WB_LSB   = 22;
   localparam int unsigned STAT_OK_BIT   = 8;
   localparam int unsigned STAT_BLK_LSB  = 16;

   // Memory modes
   localparam logic [2:0] MODE_SP_RAM  = 3'h0;
   localparam logic [2:0] MODE_SDP_RAM = 3'h1;
   localparam logic [2:0] MODE_TDP_RAM = 3'h2;
   localparam logic [2:0] MODE_TRI_RAM = 3'h3;
   localparam logic [2:0] MODE_SP_ROM  = 3'h4;
   localparam logic [2:0] MODE_DP_ROM  = 3'h5;

   // Clocking modes
   localparam logic [2:0] CLK_SINGLE = 3'h0;
   localparam logic [2:0] CLK_RDWR   = 3'h1;
   localparam logic [2:0] CLK_INOUT  = 3'h2;
   localparam logic [2:0] CLK_INDEP  = 3'h3;
   localparam logic [2:0] CLK_ASYNC  = 3'h4;

   // Block types
   localparam logic [1:0] BLK_MID   = 2'h0;
   localparam logic [1:0] BLK_LARGE = 2'h1;
   localparam logic [1:0] BLK_SMALL = 2'h2;
   localparam logic [1:0] BLK_LOGIC = 2'h3;

   // Block geometry
   localparam logic [17:0] MID_BITS      = 18'h02400;
   localparam logic [17:0] MID_DEF_DEP   = 18'h02000;
   localparam logic [17:0] MID_MIN_DEP   = 18'h00080;
   localparam logic [17:0] MID_WIDE_DEP  = 18'h00100;
   localparam logic [17:0] SMALL_MIN_DEP = 18'h00020;
   localparam logic [17:0] SMALL_MAX_DEP = 18'h00040;
   localparam logic [17:0] LARGE_MIN_DEP = 18'h01000;
   localparam logic [17:0] LARGE_MAX_DEP = 18'h20000;
   localparam logic [5:0]  MIN_MIXED_WORDS = 6'h02;
endpackage

// File: hdl/cer_mem.sv
// Dual-write storage array with per-word validity and registered reads
`timescale 1ns/10ps
module cer_mem (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rstSyncN,
   // Captured write requests
   input  wire logic                        weA,
   input  wire logic [cer_pkg::ADDR_W-1:0]  waA,
   input  wire logic [cer_pkg::DATA_W-1:0]  wdA,
   input  wire logic                        weB,
   input  wire logic [cer_pkg::ADDR_W-1:0]  waB,
   input  wire logic [cer_pkg::DATA_W-1:0]  wdB,
   // Read requests
   input  wire logic                        reA,
   input  wire logic [cer_pkg::ADDR_W-1:0]  raA,
   input  wire logic                        reB,
   input  wire logic [cer_pkg::ADDR_W-1:0]  raB,
   // Read answers
   output logic      [cer_pkg::DATA_W-1:0]  rdA,
   output logic                             unkA,
   output logic      [cer_pkg::DATA_W-1:0]  rdB,
   output logic                             unkB
);
   logic [cer_pkg::DATA_W-1:0]    store [0:cer_pkg::ARRAY_DEP-1];
   logic [cer_pkg::ARRAY_DEP-1:0] validBits;
   wire                           clash = weA && weB && (waA == waB);

   // Commit on the falling edge what was captured on the rising edge
   always_ff @(negedge clk) begin
      if (weA)
         store[waA] <= wdA;
      if (weB && !clash)
         store[waB] <= wdB;
   end

   // A clashing write leaves the word unknown until a clean write
   genvar g;
   for (g = 0; g < cer_pkg::ARRAY_DEP; g++) begin : gValid
      always_ff @(negedge clk or negedge rstSyncN) begin
         if (!rstSyncN)
            validBits[g] <= 1'b0;
         else if (clash && waA == 8'(g))
            validBits[g] <= 1'b0;
         else if ((weA && waA == 8'(g)) || (weB && waB == 8'(g)))
            validBits[g] <= 1'b1;
      end
   end

   // Reads reload every cycle so a finished write shows at once
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         rdA  <= 18'h00000;
         unkA <= 1'b0;
         rdB  <= 18'h00000;
         unkB <= 1'b0;
      end else begin
         rdA  <= (reA && validBits[raA]) ? store[raA] : 18'h00000;
         unkA <= reA && !validBits[raA];
         rdB  <= (reB && validBits[raB]) ? store[raB] : 18'h00000;
         unkB <= reB && !validBits[raB];
      end
   end
endmodule

// File: tb/cer_user_model.sv
// User logic model that drives both write and read ports of the RAM
`timescale 1ns/10ps
module cer_user_model (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Requests from the bench
   input  wire logic                        allowClash,
   input  wire logic                        reqWeA,
   input  wire logic [cer_pkg::ADDR_W-1:0]  reqAddrA,
   input  wire logic [cer_pkg::DATA_W-1:0]  reqDataA,
   input  wire logic                        reqWeB,
   input  wire logic [cer_pkg::ADDR_W-1:0]  reqAddrB,
   input  wire logic [cer_pkg::DATA_W-1:0]  reqDataB,
   // Port A pins
   output logic                             aWrEn,
   output logic      [cer_pkg::ADDR_W-1:0]  aAddr,
   output logic      [cer_pkg::DATA_W-1:0]  aWrData,
   // Port B pins
   output logic                             bWrEn,
   output logic      [cer_pkg::ADDR_W-1:0]  bAddr,
   output logic      [cer_pkg::DATA_W-1:0]  bWrData
);
   wire logic clash = reqWeA & reqWeB & (reqAddrA == reqAddrB) & ~allowClash;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aWrEn   <= 1'b0;
         bWrEn   <= 1'b0;
         aAddr   <= 8'h00;
         bAddr   <= 8'h00;
         aWrData <= 18'h00000;
         bWrData <= 18'h00000;
      end else begin
         aWrEn   <= reqWeA;
         bWrEn   <= reqWeB & ~clash;
         aAddr   <= reqAddrA;
         bAddr   <= reqAddrB;
         // Data outside a write cycle is not held
         aWrData <= reqWeA ? reqDataA : ~aWrData;
         bWrData <= reqWeB ? reqDataB : ~bWrData;
      end
   end
endmodule

// File: tb/test_configurable_embedded_ram.sv
// Self-checking bench for the configurable embedded RAM
`timescale 1ns/10ps
module test_configurable_embedded_ram;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, aWrEn, bWrEn, aRdUnknown, bRdUnknown, cfgOk, wrContention;
   logic [7:0]  aAddr, bAddr;
   logic [17:0] aWrData, bWrData, aRdData, bRdData;
   logic        allowClash = 1'b0;
   logic        reqWeA = 1'b0;
   logic        reqWeB = 1'b0;
   logic [7:0]  reqAddrA = 8'h00;
   logic [7:0]  reqAddrB = 8'h00;
   logic [17:0] reqDataA = 18'h0;
   logic [17:0] reqDataB = 18'h0;
   int          badCount = 0;
   int          cmpCount = 0;
   int          clashSeen = 0;
   logic [31:0] rdv;
   logic        errv;

   always #20 clk = ~clk;

   always @(posedge clk) begin
      if (wrContention === 1'b1) begin
         clashSeen <= clashSeen + 1;
      end
   end

   cer_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .aWrEn(aWrEn), .aAddr(aAddr), .aWrData(aWrData), .aRdData(aRdData),
      .aRdUnknown(aRdUnknown), .bWrEn(bWrEn), .bAddr(bAddr), .bWrData(bWrData),
      .bRdData(bRdData), .bRdUnknown(bRdUnknown), .cfgOk(cfgOk), .wrContention(wrContention));

   cer_user_model i_user (.clk(clk), .rst_n(rst_n), .allowClash(allowClash),
      .reqWeA(reqWeA), .reqAddrA(reqAddrA), .reqDataA(reqDataA), .reqWeB(reqWeB),
      .reqAddrB(reqAddrB), .reqDataB(reqDataB), .aWrEn(aWrEn), .aAddr(aAddr),
      .aWrData(aWrData), .bWrEn(bWrEn), .bAddr(bAddr), .bWrData(bWrData));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmpCount++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check({31'h0, pready}, 32'h1, "bus answer");
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rdv, exp, msg);
   endtask

   task automatic cfg(input logic [2:0] md, input logic [2:0] ck, input logic [1:0] bk,
      input logic emu, input logic unreg, input logic [15:0] dep, input logic [5:0] wa,
      input logic [5:0] wb, input logic [17:0] mx);
      apb(1'b1, cer_pkg::OFF_GEOM, {4'h0, wb, wa, dep});
      apb(1'b1, cer_pkg::OFF_MAXDEP, {14'h0, mx});
      apb(1'b1, cer_pkg::OFF_CTRL, {21'h0, 1'b1, unreg, emu, bk, ck, md});
      repeat (2) @(posedge clk);
   endtask

   task automatic wr2(input logic wa, input logic wb, input logic [7:0] aa, input logic [7:0] ab,
      input logic [17:0] da, input logic [17:0] db);
      @(posedge clk);
      reqWeA   <= wa;
      reqWeB   <= wb;
      reqAddrA <= aa;
      reqAddrB <= ab;
      reqDataA <= da;
      reqDataB <= db;
      @(posedge clk);
      reqWeA <= 1'b0;
      reqWeB <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic rdp(input logic [7:0] aa, input logic [7:0] ab, input logic [17:0] ea,
      input logic [17:0] eb, input logic ua, input logic ub);
      @(posedge clk);
      reqAddrA <= aa;
      reqAddrB <= ab;
      repeat (4) @(posedge clk);
      check({14'h0, aRdData}, {14'h0, ea}, "port A data");
      check({14'h0, bRdData}, {14'h0, eb}, "port B data");
      check({31'h0, aRdUnknown}, {31'h0, ua}, "port A unknown");
      check({31'h0, bRdUnknown}, {31'h0, ub}, "port B unknown");
   endtask

   task automatic shape(input logic [2:0] md, input logic [2:0] ck, input logic [1:0] bk,
      input logic unreg, input logic [15:0] dep, input logic [5:0] wa, input logic [5:0] wb,
      input logic [17:0] mx, input int bitn, input logic e);
      cfg(md, ck, bk, 1'b0, unreg, dep, wa, wb, mx);
      rchk(cer_pkg::OFF_CTRL, {21'h0, 1'b1, unreg, 1'b0, bk, ck, md}, "control probe");
      apb(1'b0, cer_pkg::OFF_STATUS, 32'h0);
      check({31'h0, rdv[bitn]}, {31'h0, e}, "status error bit");
      if (e) begin
         check({31'h0, cfgOk}, 32'h0, "config refused");
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic t_reset();
      rchk(cer_pkg::OFF_CTRL, 32'h0, "control reset");
      rchk(cer_pkg::OFF_GEOM, {4'h0, cer_pkg::GEOM_RST}, "shape reset");
      rchk(cer_pkg::OFF_MAXDEP, 32'h0, "max depth reset");
      rchk(8'h18, 32'h0, "unmapped read");
      check({31'h0, errv}, 32'h1, "unmapped error");
      check({31'h0, cfgOk}, 32'h0, "disabled after reset");
   endtask

   task automatic t_rw();
      cfg(cer_pkg::MODE_TDP_RAM, cer_pkg::CLK_SINGLE, cer_pkg::BLK_MID, 0, 0, 16'h0100,
         6'h12, 6'h12, 18'h0);
      check({31'h0, cfgOk}, 32'h1, "enabled");
      rdp(8'h09, 8'h09, 18'h0, 18'h0, 1'b1, 1'b1);
      wr2(1'b1, 1'b0, 8'h05, 8'h00, 18'h2a5a5, 18'h0);
      wr2(1'b0, 1'b1, 8'h00, 8'hff, 18'h0, 18'h1c3e7);
      rdp(8'hff, 8'h05, 18'h1c3e7, 18'h2a5a5, 1'b0, 1'b0);
   endtask

   task automatic t_clash();
      allowClash <= 1'b1;
      wr2(1'b1, 1'b1, 8'h01, 8'h01, 18'h00003, 18'h00030);
      rdp(8'h01, 8'h01, 18'h0, 18'h0, 1'b1, 1'b1);
      check(clashSeen, 32'h1, "one clash pulse");
      rchk(cer_pkg::OFF_CONTEND, 32'h1, "clash count");
      wr2(1'b1, 1'b0, 8'h01, 8'h00, 18'h00004, 18'h0);
      rdp(8'h01, 8'h01, 18'h00004, 18'h00004, 1'b0, 1'b0);
      allowClash <= 1'b0;
      wr2(1'b1, 1'b1, 8'h02, 8'h02, 18'h00011, 18'h00022);
      rdp(8'h02, 8'h02, 18'h00011, 18'h00011, 1'b0, 1'b0);
      check(clashSeen, 32'h1, "no further clash");
   endtask

   task automatic t_depth();
      cfg(cer_pkg::MODE_TDP_RAM, cer_pkg::CLK_SINGLE, cer_pkg::BLK_MID, 0, 0, 16'h0003,
         6'h12, 6'h12, 18'h0);
      rchk(cer_pkg::OFF_EFFDEP, 32'h3, "dedicated depth");
      cfg(cer_pkg::MODE_TDP_RAM, cer_pkg::CLK_SINGLE, cer_pkg::BLK_LOGIC, 0, 0, 16'h0003,
         6'h12, 6'h12, 18'h0);
      rchk(cer_pkg::OFF_EFFDEP, 32'h4, "logic depth");
      wr2(1'b1, 1'b0, 8'h03, 8'h00, 18'h12345, 18'h0);
      rdp(8'h03, 8'h03, 18'h12345, 18'h12345, 1'b0, 1'b0);
   endtask

   task automatic t_shape();
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0100, 6'h24, 6'h24, 18'h00100, 0, 1'b1);
      shape(3'h0, 3'h0, 2'h0, 0, 16'h0100, 6'h24, 6'h24, 18'h00100, 0, 1'b0);
      shape(3'h0, 3'h0, 2'h0, 0, 16'h0100, 6'h09, 6'h12, 18'h0, 1, 1'b1);
      shape(3'h2, 3'h0, 2'h3, 0, 16'h0100, 6'h09, 6'h12, 18'h0, 1, 1'b1);
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0002, 6'h09, 6'h12, 18'h0, 2, 1'b1);
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0004, 6'h09, 6'h12, 18'h0, 2, 1'b0);
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h00064, 3, 1'b1);
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h00080, 3, 1'b0);
      shape(3'h2, 3'h0, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h00040, 3, 1'b1);
      shape(3'h2, 3'h0, 2'h2, 0, 16'h0020, 6'h12, 6'h12, 18'h00040, 3, 1'b0);
      shape(3'h0, 3'h1, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b1);
      shape(3'h3, 3'h1, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b0);
      shape(3'h1, 3'h3, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b1);
      shape(3'h5, 3'h3, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b0);
      shape(3'h4, 3'h2, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b0);
      shape(3'h2, 3'h4, 2'h0, 0, 16'h0100, 6'h12, 6'h12, 18'h0, 4, 1'b1);
      shape(3'h1, 3'h4, 2'h2, 1, 16'h0020, 6'h12, 6'h12, 18'h0, 4, 1'b0);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_rw();
      t_clash();
      t_depth();
      t_shape();
      results();
   end

   // Whole run is several hundred cycles
   initial begin
      #2000000;
      badCount++;
      results();
   end
endmodule
